// *** verilog/gio_pkg.sv ***
package gio_pkg;

   // -----------------------------------------------------------------
   // Register indices and byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0]  GIO_IDX_HOT       = 8'h02;
   localparam logic [7:0]  GIO_IDX_COLD      = 8'h03;
   localparam logic [7:0]  GIO_IDX_RAIL      = 8'h04;
   localparam logic [31:0] GIO_ADDR_HOT      = {22'h0, GIO_IDX_HOT, 2'h0};
   localparam logic [31:0] GIO_ADDR_COLD     = {22'h0, GIO_IDX_COLD, 2'h0};
   localparam logic [31:0] GIO_ADDR_RAIL     = {22'h0, GIO_IDX_RAIL, 2'h0};

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int          GIO_GATE_W        = 4;
   localparam int          GIO_RAIL_W        = 2;
   localparam logic [3:0]  GIO_HOT_RST       = 4'h0;
   localparam logic [3:0]  GIO_COLD_RST      = 4'h0;
   localparam logic [1:0]  GIO_RAIL_RST      = 2'h0;

   // -----------------------------------------------------------------
   // Decode constants (volts, and tenths of a volt)
   // -----------------------------------------------------------------
   localparam logic [5:0]  GIO_HOT_BASE_V    = 6'h10;
   localparam logic [5:0]  GIO_COLD_BASE_V   = 6'h19;
   localparam logic [4:0]  GIO_DV_1V7        = 5'h11;
   localparam logic [4:0]  GIO_DV_1V8        = 5'h12;
   localparam logic [4:0]  GIO_DV_2V5        = 5'h19;
   localparam logic [4:0]  GIO_DV_OFF        = 5'h00;

   // -----------------------------------------------------------------
   // AHB-Lite encodings
   // -----------------------------------------------------------------
   localparam logic [1:0]  GIO_HTRANS_NONSEQ = 2'h2;
   localparam logic        GIO_HRESP_OKAY    = 1'h0;

   typedef enum logic [1:0]
   {
      GIO_SEL_NONE = 2'b00,
      GIO_SEL_HOT  = 2'b01,
      GIO_SEL_COLD = 2'b10,
      GIO_SEL_RAIL = 2'b11
   } gio_sel_t;

endpackage

// *** verilog/gio_gate_decode.sv ***
`timescale 1ns/1ns
module gio_gate_decode
   import gio_pkg::*;
#(
   parameter logic [5:0] BASE_V = 6'h10
)
(
   input  wire logic [3:0] code,
   output logic      [5:0] volts
);

   // -----------------------------------------------------------------
   // Linear 1 V steps from the base level
   // -----------------------------------------------------------------
   always_comb
   begin
      volts = BASE_V + {2'h0, code};
   end

endmodule

// *** verilog/gio_rail_decode.sv ***
`timescale 1ns/1ns
module gio_rail_decode
   import gio_pkg::*;
(
   input  wire logic [1:0] code,
   output logic      [4:0] buck_dv,
   output logic            ldo_en,
   output logic      [4:0] ldo_dv
);

   // -----------------------------------------------------------------
   // Rail code table
   // -----------------------------------------------------------------
   always_comb
   begin
      buck_dv = GIO_DV_1V7;
      ldo_en  = 1'b0;
      ldo_dv  = GIO_DV_OFF;
      case (code)
         2'h0:
         begin
            buck_dv = GIO_DV_1V7;
         end
         2'h1:
         begin
            buck_dv = GIO_DV_1V8;
         end
         2'h2:
         begin
            // provisional LDO level
            // Might yet become 1.8 V; kept to one constant
            buck_dv = GIO_DV_2V5;
            ldo_en  = 1'b1;
            ldo_dv  = GIO_DV_1V7;
         end
         default:
         begin
            buck_dv = GIO_DV_2V5;
            ldo_en  = 1'b1;
            ldo_dv  = GIO_DV_1V8;
         end
      endcase
   end

endmodule

// *** verilog/gio_regs.sv ***
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
module gio_regs
   import gio_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   output logic      [5:0]  gate_high_hot_volts,
   output logic      [5:0]  gate_high_cold_volts,
   output logic      [4:0]  buck_logic_output_dv,
   output logic             linear_reg_enable,
   output logic      [4:0]  linear_reg_output_dv
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed
   {
      logic [3:0]  hot;
      logic [3:0]  cold;
      logic [1:0]  rail;
      gio_sel_t    wr_sel;
      logic        ready;
      logic        resp;
      logic [31:0] rdata;
      logic [5:0]  hot_v;
      logic [5:0]  cold_v;
      logic [4:0]  buck_dv;
      logic        ldo_en;
      logic [4:0]  ldo_dv;
   } gio_state_t;

   gio_state_t s;
   gio_state_t next_s;

   logic       acc;
   gio_sel_t   a_sel;
   logic [5:0] hot_v_w;
   logic [5:0] cold_v_w;
   logic [4:0] buck_dv_w;
   logic       ldo_en_w;
   logic [4:0] ldo_dv_w;
   logic [3:0] cur_hot;
   logic [3:0] cur_cold;
   logic [1:0] cur_rail;

   // -----------------------------------------------------------------
   // Decoders
   // -----------------------------------------------------------------
   // hot level decode
   gio_gate_decode #(.BASE_V(GIO_HOT_BASE_V)) u_hot
   (
      .code  (s.hot),
      .volts (hot_v_w)
   );

   gio_gate_decode #(.BASE_V(GIO_COLD_BASE_V)) u_cold
   (
      .code  (s.cold),
      .volts (cold_v_w)
   );

   gio_rail_decode u_rail
   (
      .code    (s.rail),
      .buck_dv (buck_dv_w),
      .ldo_en  (ldo_en_w),
      .ldo_dv  (ldo_dv_w)
   );

   // -----------------------------------------------------------------
   // Address phase decode
   // -----------------------------------------------------------------
   always_comb
   begin
      // BUSY and IDLE start nothing; NONSEQ and SEQ both have bit 1 set
      acc = hsel && hready && htrans[1];
      if (haddr == GIO_ADDR_HOT)
      begin
         a_sel = GIO_SEL_HOT;
      end
      else if (haddr == GIO_ADDR_COLD)
      begin
         a_sel = GIO_SEL_COLD;
      end
      else if (haddr == GIO_ADDR_RAIL)
      begin
         a_sel = GIO_SEL_RAIL;
      end
      else
      begin
         a_sel = GIO_SEL_NONE;
      end
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      cur_hot  = s.hot;
      cur_cold = s.cold;
      cur_rail = s.rail;
      case (s.wr_sel)
         GIO_SEL_HOT:
         begin
            cur_hot = hwdata[GIO_GATE_W-1:0];
         end
         GIO_SEL_COLD:
         begin
            cur_cold = hwdata[GIO_GATE_W-1:0];
         end
         GIO_SEL_RAIL:
         begin
            cur_rail = hwdata[GIO_RAIL_W-1:0];
         end
         default:
         begin
         end
      endcase
      next_s.hot  = cur_hot;
      next_s.cold = cur_cold;
      next_s.rail = cur_rail;
      // Zero wait states; every answer is OKAY
      next_s.ready = 1'b1;
      next_s.resp  = GIO_HRESP_OKAY;
      next_s.wr_sel = GIO_SEL_NONE;
      if (acc && hwrite)
      begin
         next_s.wr_sel = a_sel;
      end
      // Read data from post-write values, so a read right after
      // a write to the same register already sees the new field
      if (acc && !hwrite)
      begin
         case (a_sel)
            GIO_SEL_HOT:
            begin
               next_s.rdata = {28'h0, cur_hot};
            end
            GIO_SEL_COLD:
            begin
               next_s.rdata = {28'h0, cur_cold};
            end
            GIO_SEL_RAIL:
            begin
               next_s.rdata = {30'h0, cur_rail};
            end
            default:
            begin
               next_s.rdata = 32'h0;
            end
         endcase
      end
      next_s.hot_v   = hot_v_w;
      next_s.cold_v  = cold_v_w;
      next_s.buck_dv = buck_dv_w;
      next_s.ldo_en  = ldo_en_w;
      next_s.ldo_dv  = ldo_dv_w;
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s.hot     <= GIO_HOT_RST;
         s.cold    <= GIO_COLD_RST;
         s.rail    <= GIO_RAIL_RST;
         s.wr_sel  <= GIO_SEL_NONE;
         s.ready   <= 1'b1;
         s.resp    <= GIO_HRESP_OKAY;
         s.rdata   <= 32'h0;
         s.hot_v   <= GIO_HOT_BASE_V;
         s.cold_v  <= GIO_COLD_BASE_V;
         s.buck_dv <= GIO_DV_1V7;
         s.ldo_en  <= 1'b0;
         s.ldo_dv  <= GIO_DV_OFF;
      end
      else
      begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign hreadyout            = s.ready;
   assign hresp                = s.resp;
   assign hrdata               = s.rdata;
   assign gate_high_hot_volts  = s.hot_v;
   assign gate_high_cold_volts = s.cold_v;
   assign buck_logic_output_dv = s.buck_dv;
   assign linear_reg_enable    = s.ldo_en;
   assign linear_reg_output_dv = s.ldo_dv;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_HOT_UPPER_ZERO: assert property (
      acc && !hwrite && haddr == GIO_ADDR_HOT |=> hrdata[31:4] == 28'h0)
      else $error("hot register upper bits not zero");

   AST_RAIL_UPPER_ZERO: assert property (
      acc && !hwrite && haddr == GIO_ADDR_RAIL |=> hrdata[31:2] == 30'h0)
      else $error("rail register upper bits not zero");

   AST_COLD_UPPER_ZERO: assert property (
      acc && !hwrite && haddr == GIO_ADDR_COLD |=> hrdata[31:4] == 28'h0)
      else $error("cold register upper bits not zero");

   AST_HOT_READBACK: assert property (
      acc && hwrite && haddr == GIO_ADDR_HOT ##1 !(acc && hwrite) ##1
      acc && !hwrite && haddr == GIO_ADDR_HOT
      |=> hrdata[3:0] == $past(hwdata[3:0], 2))
      else $error("hot register readback mismatch");

   AST_COLD_STORE: assert property (
      acc && hwrite && haddr == GIO_ADDR_COLD
      |=> ##1 s.cold == $past(hwdata[3:0]))
      else $error("cold register did not store write");

   AST_COLD_READBACK: assert property (
      acc && hwrite && haddr == GIO_ADDR_COLD ##1 !(acc && hwrite) ##1
      acc && !hwrite && haddr == GIO_ADDR_COLD
      |=> hrdata[3:0] == $past(hwdata[3:0], 2))
      else $error("cold register readback mismatch");

   AST_RAIL_STORE: assert property (
      acc && hwrite && haddr == GIO_ADDR_RAIL
      |=> ##1 s.rail == $past(hwdata[1:0]))
      else $error("rail register did not store write");

   AST_RAIL_READBACK: assert property (
      acc && hwrite && haddr == GIO_ADDR_RAIL ##1 !(acc && hwrite) ##1
      acc && !hwrite && haddr == GIO_ADDR_RAIL
      |=> hrdata[1:0] == $past(hwdata[1:0], 2))
      else $error("rail register readback mismatch");

   AST_HOT_DECODE: assert property (
      s.hot == 4'hF |=> gate_high_hot_volts == 6'h1F)
      else $error("hot code F not decoded to 31 V");

   AST_COLD_DECODE: assert property (
      1'b1 |=> gate_high_cold_volts == 6'h19 + {2'h0, $past(s.cold)})
      else $error("cold level decode wrong");

   AST_RAIL_CODE0: assert property (
      s.rail == 2'h0 |=> buck_logic_output_dv == 5'h11 && !linear_reg_enable)
      else $error("rail code 0 decode wrong");

   AST_RAIL_CODE1: assert property (
      s.rail == 2'h1 |=> buck_logic_output_dv == 5'h12 && !linear_reg_enable
                         && linear_reg_output_dv == 5'h00)
      else $error("rail code 1 decode wrong");

   AST_RAIL_CODE3: assert property (
      s.rail == 2'h3 |=> buck_logic_output_dv == 5'h19 && linear_reg_enable
                         && linear_reg_output_dv == 5'h12)
      else $error("rail code 3 decode wrong");

   AST_RAIL_CODE2: assert property (
      s.rail == 2'h2 |=> linear_reg_enable && linear_reg_output_dv == 5'h11
                         && buck_logic_output_dv == 5'h19)
      else $error("rail code 2 decode wrong");

   COV_HOT_WRITE: cover property (
      acc && hwrite && haddr == GIO_ADDR_HOT);
   COV_RAIL_READ: cover property (
      acc && !hwrite && haddr == GIO_ADDR_RAIL);
   COV_LDO_ON: cover property (
      !linear_reg_enable ##1 linear_reg_enable);
   COV_RAIL_CODE2: cover property (
      s.rail == 2'h2);
   COV_HOT_MAX: cover property (
      s.hot == 4'hF);

endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb
   import gio_pkg::*;
();

   // ----------------------------------------------------------------
   // Clock, bus and design
   // ----------------------------------------------------------------
   logic        hclk    = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel    = 1'h0;
   logic        hwrite  = 1'h0;
   logic [1:0]  htrans  = 2'h0;
   logic [2:0]  hsize   = 3'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [5:0]  gate_high_hot_volts;
   logic [5:0]  gate_high_cold_volts;
   logic [4:0]  buck_logic_output_dv;
   logic        linear_reg_enable;
   logic [4:0]  linear_reg_output_dv;
   int          n_fail  = 0;
   int          checked = 0;
   logic [31:0] mdl [4];
   logic [31:0] adr [4];
   logic [31:0] msk [4];
   logic [31:0] rd;

   always #10 hclk = ~hclk;

   // Single slave: its hreadyout is the bus hready
   gio_regs i_dut
   (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (hsize),
      .hwdata               (hwdata),
      .hready               (hreadyout),
      .hreadyout            (hreadyout),
      .hresp                (hresp),
      .hrdata               (hrdata),
      .gate_high_hot_volts  (gate_high_hot_volts),
      .gate_high_cold_volts (gate_high_cold_volts),
      .buck_logic_output_dv (buck_logic_output_dv),
      .linear_reg_enable    (linear_reg_enable),
      .linear_reg_output_dv (linear_reg_output_dv)
   );

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic complete_run;
      if (n_fail == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [10:0] rail_exp(input logic [1:0] c);
      case (c)
         2'h0:    rail_exp = {GIO_DV_1V7, 1'h0, GIO_DV_OFF};
         2'h1:    rail_exp = {GIO_DV_1V8, 1'h0, GIO_DV_OFF};
         2'h2:    rail_exp = {GIO_DV_2V5, 1'h1, GIO_DV_1V7};
         default: rail_exp = {GIO_DV_2V5, 1'h1, GIO_DV_1V8};
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Bus master: waits on hready; only the watchdog ends a stuck wait
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      htrans <= GIO_HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      hsel   <= 1'h1;
      do
      begin
         @(posedge hclk);
      end
      while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do
      begin
         @(posedge hclk);
      end
      while (hreadyout !== 1'h1);
      r = hrdata;
      chk(32'(hresp), 32'(GIO_HRESP_OKAY));
   endtask

   task automatic outs;
      chk(32'(gate_high_hot_volts), 32'(GIO_HOT_BASE_V + mdl[0][3:0]));
      chk(32'(gate_high_cold_volts), 32'(GIO_COLD_BASE_V + mdl[1][3:0]));
      chk(32'({buck_logic_output_dv, linear_reg_enable,
               linear_reg_output_dv}), 32'(rail_exp(mdl[2][1:0])));
   endtask

   // Read-back follows the write's data phase with an idle cycle, so back-to-back order is not covered
   task automatic wr_chk(input int r, input logic [31:0] d);
      bus(1'h1, adr[r], d, rd);
      mdl[r] = d & msk[r];
      bus(1'h0, adr[r], $urandom, rd);
      chk(rd, mdl[r]);
      outs();
   endtask

   task automatic rst_chk;
      hresetn <= 1'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      mdl = '{default: 32'h0};
      for (int i = 0; i < 4; i++)
      begin
         bus(1'h0, adr[i], 32'h0, rd);
         chk(rd, 32'h0);
      end
      outs();
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      complete_run();
   end

   initial
   begin
      // Slot 3 is an unmapped word: writes vanish, reads give zero
      adr = '{GIO_ADDR_HOT, GIO_ADDR_COLD, GIO_ADDR_RAIL, 32'h0000_0014};
      msk = '{32'h0000_000F, 32'h0000_000F, 32'h0000_0003, 32'h0};
      void'($urandom(32'hC0E4));
      rst_chk();
      for (int r = 0; r < 3; r++)
         for (int c = 0; c <= msk[r]; c++)
            wr_chk(r, ($urandom & ~msk[r]) | c);
      wr_chk(3, 32'hFFFF_FFFF);
      repeat (150)
      begin
         int r;
         r = $urandom_range(3);
         if ($urandom_range(1) == 1)
            wr_chk(r, $urandom);
         else
         begin
            bus(1'h0, adr[r], $urandom, rd);
            chk(rd, mdl[r]);
         end
      end
      rst_chk();
      wr_chk(2, 32'hFFFF_FFFE);
      complete_run();
   end

endmodule
